// >>> sim/appi_psram.sv
`timescale 1ns/1ps
module appi_psram #(
   parameter int INIT_CYCLES = 100
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire appi_pkg::appi_pins_t pins,
   input wire logic [15:0] dq,
   output logic [15:0] mem_dq,
   output logic [1:0] mem_oe,
   output logic [7:0] viol
);
   import appi_pkg::*;
   logic [15:0] mem [0:255];
   logic [15:0] init_cnt, pd, val;
   logic [19:0] cfg_reg;
   logic [9:0] slp_cnt;
   logic [7:0] sel_cnt;
   logic [2:0] rd_cnt, was;
   logic [1:0] mode, seq;
   logic sw_used, wr, rd, ld, on;
   appi_pins_t p;
   // nothing moves during init or either sleep mode
   assign on = init_cnt == 0 && mode == 0 && pins.sleep_req_n && !pins.chip_sel_n;
   assign wr = on && !pins.wr_en_n && !(pins.low_lane_n && pins.high_lane_n);
   assign rd = on && !pins.out_en_n && pins.wr_en_n;
   assign ld = !pins.sleep_req_n && !pins.chip_sel_n && !pins.wr_en_n;
   assign val = (pins.addr == TOP_ADDR && seq == 3) ? cfg_reg[15:0] : mem[pins.addr[7:0]];
   // full access time counted from each read strobe; an address change while the strobe stays low is not delayed
   assign mem_dq = rd_cnt < 3'(ACCESS_CYC - 1) ? ~val : val;
   assign mem_oe = rd ? ~{pins.high_lane_n, pins.low_lane_n} : 2'h0;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= CFG_RESET;
         was <= 3'h0;
         init_cnt <= 16'(INIT_CYCLES);
         mode <= 2'h0;
         seq <= 2'h0;
         sw_used <= 1'b0;
         viol <= 8'h00;
      end else begin
         p <= pins;
         pd <= dq;
         was <= {wr, rd, ld};
         rd_cnt <= rd ? rd_cnt + 3'(rd_cnt != 3'h7) : 3'h0;
         sel_cnt <= pins.chip_sel_n ? 8'h00 : sel_cnt + 8'h01;
         if (init_cnt != 0)
            init_cnt <= init_cnt - 16'h0001;
         if ((init_cnt != 0 && !pins.chip_sel_n) || sel_cnt > 8'(SEL_MAX_CYC))
            viol <= viol + 8'h01;
         if (pins.sleep_req_n) begin
            slp_cnt <= 10'h000;
            mode <= 2'h0;
            // wake seen one edge late, so one count less keeps pace with the host
            if (mode == 2)
               init_cnt <= 16'(INIT_CYCLES - 1);
         end else begin
            slp_cnt <= slp_cnt + 10'(slp_cnt != 10'h3ff);
            if (slp_cnt == 10'(SLEEP_CYC) && mode == 0 && !(cfg_reg[SLEEP_BIT] && sw_used)) begin
               mode <= cfg_reg[SLEEP_BIT] ? 2'h1 : 2'h2;
               if (!cfg_reg[SLEEP_BIT] || cfg_reg[2:0] == 3'h4)
                  for (int i = 0; i < 256; i++)
                     mem[i] <= ~mem[i];
            end
         end
         if (was[2] && !wr) begin
            if (p.addr == TOP_ADDR && seq == 3) begin
               cfg_reg[15:0] <= pd;
               sw_used <= 1'b1;
               mode <= {1'b0, pd[SLEEP_BIT]};
               seq <= 2'h0;
               if (!pd[SLEEP_BIT])
                  viol <= viol + 8'h01;
            end else if (p.addr == TOP_ADDR && seq == 2) begin
               seq <= 2'h3;
            end else begin
               seq <= 2'h0;
               if (!p.low_lane_n)
                  mem[p.addr[7:0]][7:0] <= pd[7:0];
               if (!p.high_lane_n)
                  mem[p.addr[7:0]][15:8] <= pd[15:8];
            end
         end
         if (was[1] && !rd)
            seq <= (p.addr == TOP_ADDR && seq < 2) ? seq + 2'h1 : 2'h0;
         if (was[0] && !ld && !pins.sleep_req_n && init_cnt == 0)
            cfg_reg <= p.addr;
      end
   end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import appi_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   appi_axi_req_t axi_req = '0;
   appi_axi_rsp_t axi_rsp;
   appi_pins_t pins;
   logic [15:0] dq_in, mem_dq;
   logic [15:0] flt = 16'h5a5a;
   logic [1:0] mem_oe, resp;
   logic [7:0] viol;
   logic [31:0] rd_val;
   int err_total = 0;
   int compares = 0;
   always #10 mclk = ~mclk;
   // released lines toggle so a stale value never looks driven
   always @(posedge mclk) flt <= ~flt;
   assign dq_in[7:0] = !pins.dq_oe_n ? pins.dq_out[7:0] : mem_oe[0] ? mem_dq[7:0] : flt[7:0];
   assign dq_in[15:8] = !pins.dq_oe_n ? pins.dq_out[15:8] : mem_oe[1] ? mem_dq[15:8] : flt[15:8];
   appi_host #(.INIT_CYCLES(100)) i_appi_host (.mclk(mclk), .resetn(resetn), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .pins(pins), .dq_in(dq_in));
   appi_psram #(.INIT_CYCLES(100)) i_appi_psram (.mclk(mclk), .resetn(resetn), .pins(pins),
      .dq(dq_in), .mem_dq(mem_dq), .mem_oe(mem_oe), .viol(viol));
   task automatic close_out;
      if (err_total == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic lost;
      err_total++;
      $display("CHECK FAILED %0t wait ran out", $time);
      close_out();
   endtask
   task automatic step(inout int n);
      @(posedge mclk);
      n++;
      if (n > 60)
         lost();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge mclk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do step(n); while (axi_rsp.awready !== 1'b1);
      axi_req.awvalid <= 1'b0;
      axi_req.wvalid <= 1'b0;
      while (axi_rsp.bvalid !== 1'b1) step(n);
      resp = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int n = 0;
      @(posedge mclk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do step(n); while (axi_rsp.arready !== 1'b1);
      axi_req.arvalid <= 1'b0;
      while (axi_rsp.rvalid !== 1'b1) step(n);
      rd_val = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      axi_wr(a, d);
      check(32'(resp), 32'(e));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      axi_rd(a);
      check(rd_val & m, e);
   endtask
   task automatic ctrl(input appi_cmd_t c);
      wr(OFF_CTRL, 32'h8000_0000 | 32'(c), RESP_OKAY);
   endtask
   task automatic wait_st(input logic [31:0] m, input logic [31:0] e);
      int n = 0;
      do begin
         axi_rd(OFF_STATUS);
         n++;
      end while ((rd_val & m) !== e && n < 250);
      if ((rd_val & m) !== e)
         lost();
   endtask
   task automatic pin_op(input logic [19:0] a, input logic [17:0] d, input appi_cmd_t c);
      wr(OFF_ADDR, {12'h000, a}, RESP_OKAY);
      wr(OFF_WDATA, {14'h0000, d}, RESP_OKAY);
      ctrl(c);
      wait_st(32'h3, 32'h2);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      rd_chk(OFF_CFG, 32'h000f_ffff, 32'h0000_0070);
      check(32'(i_appi_psram.cfg_reg), 32'h0000_0070);
      rd_chk(OFF_STATUS, 32'h2, 32'h0);
      wait_st(32'h3, 32'h2);
      pin_op(20'h0_0012, 18'h3_a55a, CMD_WRITE);
      check(32'(i_appi_psram.mem[8'h12]), 32'h0000_a55a);
      pin_op(20'h0_0012, 18'h1_1234, CMD_WRITE);
      pin_op(20'h0_0012, 18'h3_0000, CMD_READ);
      rd_chk(OFF_RDATA, 32'hffff_ffff, 32'h0000_a534);
      pin_op(20'h0_0012, 18'h2_0000, CMD_READ);
      rd_chk(OFF_RDATA, 32'hffff_ff00, 32'h0000_a500);
      pin_op(20'h0_0012, 18'h0_ffff, CMD_WRITE);
      check(32'(i_appi_psram.mem[8'h12]), 32'h0000_a534);
      wr(OFF_CFG, 32'h0000_0080, RESP_OKAY);
      pin_op(20'h0_0000, 18'h3_0000, CMD_CFG_PIN);
      check(32'(i_appi_psram.cfg_reg), 32'h0000_0080);
      rd_chk(OFF_MIRROR, 32'h000f_ffff, 32'h0000_0080);
      pin_op(20'h0_0000, 18'h3_0000, CMD_SW_RD);
      rd_chk(OFF_RDATA, 32'hffff_ffff, 32'h0000_0080);
      check(32'(i_appi_psram.sw_used), 32'h0);
      ctrl(CMD_SLEEP);
      wait_st(32'h4, 32'h4);
      check(32'(i_appi_psram.mode), 32'h2);
      ctrl(CMD_WAKE);
      rd_chk(OFF_STATUS, 32'h2, 32'h0);
      wait_st(32'h3, 32'h2);
      pin_op(20'hf_ffff, 18'h3_beef, CMD_WRITE);
      wr(OFF_CFG, 32'h0000_0061, RESP_OKAY);
      pin_op(20'h0_0000, 18'h3_0000, CMD_SW_WR);
      check(32'(i_appi_psram.cfg_reg), 32'h0000_0071);
      rd_chk(OFF_STATUS, 32'h8, 32'h8);
      pin_op(20'hf_ffff, 18'h3_0000, CMD_READ);
      rd_chk(OFF_RDATA, 32'hffff_ffff, 32'h0000_beef);
      ctrl(CMD_SLEEP);
      wait_st(32'h4, 32'h4);
      check(32'(i_appi_psram.mode), 32'h0);
      ctrl(CMD_WAKE);
      rd_chk(OFF_STATUS, 32'h6, 32'h2);
      rd_chk(OFF_CTRL, 32'h7, 32'h6);
      wr(OFF_CTRL, 32'h8000_0007, RESP_OKAY);
      rd_chk(OFF_CTRL, 32'h7, 32'h6);
      rd_chk(OFF_STATUS, 32'h1, 32'h0);
      axi_rd(8'h1c);
      check(rd_val, 32'h0);
      check(32'(resp), 32'(RESP_SLVERR));
      wr(8'h20, 32'h0, RESP_SLVERR);
      check(32'(viol), 32'h0);
      close_out();
   end
endmodule

// >>> src/appi_host.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// - controller holds chip select high and idle through power-up initialization.
// - read is select, output enable, lanes low with write enable high.
// - controller never keeps chip select low beyond the maximum select-low time.
// - system picks a temperature threshold above the case temperature.
// - leaving deep power-down takes 150us; controller waits before accesses.
// - deep power-down is entered and left only through the sleep pin.
// - pin load writes right after sleep request falls; address bits are latched.
// - software sequence is two reads, a write, then a write (config write) or a read (config read) at top address.
module appi_host #(
   parameter int INIT_CYCLES = appi_pkg::INIT_CYC
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire appi_pkg::appi_axi_req_t axi_req,
   output appi_pkg::appi_axi_rsp_t axi_rsp,
   output appi_pkg::appi_pins_t pins,
   input wire logic [15:0] dq_in
);
   import appi_pkg::*;

   typedef struct packed {
      appi_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [1:0] step;
      appi_cmd_t cmd;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0] lanes;
      logic [19:0] cfg;
      logic [19:0] mirror;
      logic [15:0] rdata;
      logic sw_used;
      logic [7:0] sel_cnt;
      appi_pins_t pins;
      appi_axi_rsp_t rsp;
   } appi_regs_t;

   // highest temperature threshold by default, safe for any case temperature
   localparam appi_regs_t REGS_RESET = '{st: ST_INIT, cnt: '0, step: 2'h0, cmd: CMD_READ, addr: 20'h0_0000,
      wdata: 16'h0000, lanes: 2'h3, cfg: CFG_RESET, mirror: CFG_RESET, rdata: 16'h0000, sw_used: 1'h0,
      sel_cnt: 8'h00, pins: PINS_IDLE, rsp: '0};

   appi_regs_t s, n;
   logic wr_fire, rd_fire, go, is_sw, step_wr;
   logic [1:0] nstep;
   logic [15:0] sw_word;
   logic [31:0] rd_word;
   appi_cmd_t go_cmd;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic appi_pins_t access(input appi_pins_t p, input logic wr, input logic [19:0] a,
                                         input logic [15:0] d, input logic [1:0] ln);
      appi_pins_t r;
      r = p;
      r.addr = a;
      r.chip_sel_n = 1'h0;
      r.wr_en_n = ~wr;
      r.out_en_n = wr;
      r.low_lane_n = ~ln[0];
      r.high_lane_n = ~ln[1];
      r.dq_out = d;
      r.dq_oe_n = ~wr;
      return r;
   endfunction

   always_comb begin
      n = s;
      wr_fire = s.rsp.awready & axi_req.awvalid & axi_req.wvalid;
      rd_fire = s.rsp.arready & axi_req.arvalid;
      go_cmd = appi_cmd_t'(axi_req.wdata[2:0]);
      go = wr_fire && axi_req.awaddr == OFF_CTRL && axi_req.wstrb[3] && axi_req.wdata[START_BIT];
      is_sw = s.cmd == CMD_SW_WR || s.cmd == CMD_SW_RD;
      nstep = s.step + 2'h1;
      step_wr = nstep[1] && !(nstep == 2'h3 && s.cmd == CMD_SW_RD);
      // deep power-down never reached by software: sleep bit forced on
      sw_word = s.cfg[15:0] | SW_SLEEP_MASK;

      n.rsp.awready = ~s.rsp.awready & axi_req.awvalid & axi_req.wvalid & ~s.rsp.bvalid;
      n.rsp.wready = n.rsp.awready;
      n.rsp.arready = ~s.rsp.arready & axi_req.arvalid & ~s.rsp.rvalid;
      if (s.rsp.bvalid && axi_req.bready) begin
         n.rsp.bvalid = 1'h0;
      end
      if (s.rsp.rvalid && axi_req.rready) begin
         n.rsp.rvalid = 1'h0;
      end
      if (wr_fire) begin
         n.rsp.bvalid = 1'h1;
         n.rsp.bresp = RESP_OKAY;
         case (axi_req.awaddr)
            OFF_ADDR: n.addr = 20'(merge({12'h000, s.addr}, axi_req.wdata, axi_req.wstrb));
            OFF_WDATA: {n.lanes, n.wdata} = 18'(merge({14'h0000, s.lanes, s.wdata}, axi_req.wdata, axi_req.wstrb));
            OFF_CFG: n.cfg = 20'(merge({12'h000, s.cfg}, axi_req.wdata, axi_req.wstrb));
            OFF_CTRL, OFF_RDATA, OFF_STATUS, OFF_MIRROR: begin
            end
            default: n.rsp.bresp = RESP_SLVERR;
         endcase
      end

      rd_word = 32'h0000_0000;
      case (axi_req.araddr)
         OFF_CTRL: rd_word = {29'h0000_0000, s.cmd};
         OFF_ADDR: rd_word = {12'h000, s.addr};
         OFF_WDATA: rd_word = {14'h0000, s.lanes, s.wdata};
         OFF_CFG: rd_word = {12'h000, s.cfg};
         OFF_RDATA: rd_word = {16'h0000, s.rdata};
         OFF_STATUS: rd_word = {28'h000_0000, s.sw_used, s.st == ST_SLEEP,
                                s.st != ST_INIT && s.st != ST_WAKE, s.st != ST_IDLE};
         OFF_MIRROR: rd_word = {12'h000, s.mirror};
         default: rd_word = 32'h0000_0000;
      endcase
      if (rd_fire) begin
         n.rsp.rvalid = 1'h1;
         n.rsp.rdata = rd_word;
         n.rsp.rresp = (axi_req.araddr > OFF_MIRROR || axi_req.araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end

      n.sel_cnt = s.pins.chip_sel_n ? 8'h00 : s.sel_cnt + 8'h01;

      unique case (s.st)
         ST_INIT, ST_WAKE: begin
            // select stays high until the device has finished initializing
            n.cnt = s.cnt + CNT_W'(1);
            if (s.cnt == CNT_W'(INIT_CYCLES - 1)) begin
               n.st = ST_IDLE;
               n.cnt = '0;
            end
         end
         ST_IDLE: begin
            if (go && go_cmd != CMD_WAKE && axi_req.wdata[2:0] <= CMD_WAKE) begin
               n.cmd = go_cmd;
               n.step = 2'h0;
               n.cnt = '0;
               case (go_cmd)
                  CMD_READ, CMD_WRITE: begin
                     n.st = ST_ACC;
                     n.pins = access(s.pins, go_cmd == CMD_WRITE, s.addr, s.wdata, s.lanes);
                  end
                  CMD_SW_WR, CMD_SW_RD: begin
                     n.st = ST_ACC;
                     n.pins = access(s.pins, 1'h0, TOP_ADDR, 16'h0000, 2'h3);
                  end
                  default: begin
                     n.st = ST_SLEEP_REQ;
                     n.pins.sleep_req_n = 1'h0;
                  end
               endcase
            end
         end
         ST_SLEEP_REQ: begin
            n.cnt = s.cnt + CNT_W'(1);
            if (s.cmd == CMD_CFG_PIN) begin
               // config value rides on the address; lanes and data bus stay off
               n.st = ST_ACC;
               n.cnt = '0;
               n.pins = access(s.pins, 1'h1, s.cfg, 16'h0000, 2'h0);
               n.pins.dq_oe_n = 1'h1;
            end else if (s.cnt == CNT_W'(SLEEP_CYC - 1)) begin
               n.st = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (go && go_cmd == CMD_WAKE) begin
               n.cmd = go_cmd;
               n.pins.sleep_req_n = 1'h1;
               n.cnt = '0;
               n.st = s.mirror[SLEEP_BIT] ? ST_IDLE : ST_WAKE;
            end
         end
         ST_ACC: begin
            n.cnt = s.cnt + CNT_W'(1);
            if (s.cnt == CNT_W'(ACCESS_CYC - 1)) begin
               if (s.pins.wr_en_n) begin
                  n.rdata = dq_in;
               end
               // every select-low stretch is one access, far below the limit
               n.pins.chip_sel_n = 1'h1;
               n.pins.out_en_n = 1'h1;
               n.pins.wr_en_n = 1'h1;
               n.pins.low_lane_n = 1'h1;
               n.pins.high_lane_n = 1'h1;
               n.st = ST_REC;
               n.cnt = '0;
            end
         end
         ST_REC: begin
            // data held one cycle past the rising edges for hold margin
            n.pins.dq_oe_n = 1'h1;
            if (is_sw && s.step != 2'h3) begin
               n.step = nstep;
               n.st = ST_ACC;
               n.pins = access(s.pins, step_wr, TOP_ADDR, nstep == 2'h3 ? sw_word : 16'h0000, 2'h3);
            end else begin
               n.st = ST_IDLE;
               n.pins.sleep_req_n = 1'h1;
               if (s.cmd == CMD_CFG_PIN) begin
                  n.mirror = s.cfg;
               end
               if (s.cmd == CMD_SW_WR) begin
                  n.mirror = {4'h0, sw_word};
                  n.sw_used = 1'h1;
               end
               if (s.cmd == CMD_SW_RD) begin
                  n.mirror = {4'h0, s.rdata};
               end
            end
         end
         default: n.st = ST_INIT;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s <= REGS_RESET;
      end else begin
         s <= n;
      end
   end

   assign pins = s.pins;
   assign axi_rsp = s.rsp;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_init_select_high: assert property ((s.st == ST_INIT || s.st == ST_WAKE) |-> s.pins.chip_sel_n)
      else $error("select low during initialization");
   a_init_length: assert property (s.st == ST_IDLE && $past(s.st) == ST_INIT |-> $past(s.cnt) == CNT_W'(INIT_CYCLES - 1))
      else $error("initialization wait cut short");
   a_select_low_bound: assert property (s.sel_cnt < 8'(SEL_MAX_CYC))
      else $error("select held low too long");
   a_read_levels: assert property ($fell(s.pins.chip_sel_n) && s.pins.wr_en_n |->
      (!s.pins.out_en_n && !s.pins.chip_sel_n && s.pins.dq_oe_n)[*4] ##1 s.pins.chip_sel_n)
      else $error("read strobes wrong");
   // a software write may follow straight on, keeping the bus driven
   a_write_data_hold: assert property ($rose(s.pins.wr_en_n) && !$past(s.pins.dq_oe_n) |->
      !s.pins.dq_oe_n ##1 (s.pins.dq_oe_n || !s.pins.wr_en_n))
      else $error("write data not held past strobe");
   a_sw_top_addr: assert property (is_sw && s.st == ST_ACC |-> s.pins.addr == TOP_ADDR)
      else $error("software sequence off top address");
   a_sw_no_deep: assert property (s.cmd == CMD_SW_WR && s.st == ST_ACC && s.step == 2'h3 |-> s.pins.dq_out[SLEEP_BIT])
      else $error("software write clears sleep bit");
   a_pin_load_write: assert property ($fell(s.pins.sleep_req_n) && s.cmd == CMD_CFG_PIN |=>
      !s.pins.chip_sel_n && !s.pins.wr_en_n && s.pins.addr == s.cfg && !s.pins.sleep_req_n)
      else $error("pin load write missing");
   a_wake_wait: assert property ($rose(s.pins.sleep_req_n) && s.st == ST_WAKE |-> s.pins.chip_sel_n[*8])
      else $error("access during wake-up");
endmodule

// >>> src/appi_pkg.sv
package appi_pkg;
   localparam int CLK_NS = 20;
   localparam int INIT_US = 150;
   localparam int INIT_CYC = (INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_US = 10;
   // strictly longer than the sleep threshold
   localparam int SLEEP_CYC = SLEEP_US * 1000 / CLK_NS + 1;
   localparam int ACCESS_NS = 70;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEL_MAX_NS = 4000;
   localparam int SEL_MAX_CYC = SEL_MAX_NS / CLK_NS;
   localparam int CNT_W = 13;
   localparam logic [19:0] TOP_ADDR = 20'hf_ffff;
   localparam logic [19:0] CFG_RESET = 20'h0_0070;
   localparam int SLEEP_BIT = 4;
   localparam logic [15:0] SW_SLEEP_MASK = 16'h0010;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_CFG = 8'h0c;
   localparam logic [7:0] OFF_RDATA = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_MIRROR = 8'h18;
   localparam int START_BIT = 31;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0, CMD_WRITE = 3'h1, CMD_CFG_PIN = 3'h2, CMD_SW_WR = 3'h3,
      CMD_SW_RD = 3'h4, CMD_SLEEP = 3'h5, CMD_WAKE = 3'h6
   } appi_cmd_t;

   typedef enum logic [2:0] {
      ST_INIT = 3'h0, ST_IDLE = 3'h1, ST_ACC = 3'h3, ST_REC = 3'h2,
      ST_SLEEP_REQ = 3'h6, ST_SLEEP = 3'h7, ST_WAKE = 3'h5
   } appi_state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic chip_sel_n;
      logic out_en_n;
      logic wr_en_n;
      logic low_lane_n;
      logic high_lane_n;
      logic sleep_req_n;
      logic [15:0] dq_out;
      logic dq_oe_n;
   } appi_pins_t;

   localparam appi_pins_t PINS_IDLE = '{addr: 20'h0_0000, chip_sel_n: 1'h1, out_en_n: 1'h1, wr_en_n: 1'h1,
      low_lane_n: 1'h1, high_lane_n: 1'h1, sleep_req_n: 1'h1, dq_out: 16'h0000, dq_oe_n: 1'h1};

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } appi_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } appi_axi_rsp_t;
endpackage
